// [core/ram_port_pkg.sv]
// Package with the constants shared by the RAM port top and its storage array.
// Assumes a single 25 MHz clock domain for both the logic and the host.
package ram_port_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] CLEAR_ADDR = 17'h00000;
    localparam logic [ADDR_W-1:0] COUNT_STEP = 17'h00001;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    // Port-to-port timing, in ns, as seen by the host.
    localparam int CLK_PERIOD_NS = 40;
    localparam int WRITE_TO_READ_DELAY_NS = 35;
    localparam int CLOCK_TO_CLOCK_WINDOW_NS = 10;
    localparam int FLOW_ACCESS_TIME_NS = 18;
    localparam int FLOW_CYCLE_TIME_NS = 22;
    localparam int PIPE_CYCLE_TIME_NS = 12;
    localparam int WRITE_TO_READ_CYCLES =
        (WRITE_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// [core/ram_access_if.sv]
// Interface carrying one access from the port logic to the storage array.
// Assumes both ends share the port clock.
`timescale 1ns/100ps
interface ram_access_if #(parameter int AW = 17, parameter int DW = 8);
    logic wr_en;
    logic rd_en;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport port (output wr_en, output rd_en, output addr, output wdata, input rdata);
    modport mem (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface

// [core/ram_array.sv]
// Byte-wide synchronous storage array with registered read data.
// Assumes the other port writes through its own array copy or shared wrapper.
`timescale 1ns/100ps
module ram_array
    import ram_port_pkg::*;
#(
    parameter int DEPTH = 2 ** ADDR_W
) (
    input wire logic clk,
    ram_access_if.mem acc
);
    logic [DATA_W-1:0] mem_q [DEPTH];
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (acc.wr_en) begin
            rdata_d = acc.wdata;
        end else if (acc.rd_en) begin
            rdata_d = mem_q[acc.addr];
        end
    end

    always_ff @(posedge clk) begin
        if (acc.wr_en) begin
            mem_q[acc.addr] <= acc.wdata;
        end
        rdata_q <= rdata_d;
    end

    assign acc.rdata = rdata_q;
endmodule

// [core/ram_port.sv]
// One port of a synchronous dual-port RAM with burst address counter.
// Assumes host inputs are synchronous to clk; output enable is sampled with
// the other pins and folded into data_out_en_n, which gates the pin drivers.
`timescale 1ns/100ps
module ram_port
    import ram_port_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic address_strobe_n,
    input wire logic count_advance_n,
    input wire logic counter_clear_n,
    input wire logic select_low_active,
    input wire logic select_high_active,
    input wire logic read_write,
    input wire logic output_mode_select,
    input wire logic output_enable_n,
    output logic [DATA_W-1:0] data_out,
    output logic data_out_en_n,
    output logic [ADDR_W-1:0] burst_address
);
    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Pins come from a host on the same clock; the stages are kept because
    // they are the input registers of the port anyway.
    logic [ADDR_W-1:0] addr_s1_q, addr_s2_q;
    logic [DATA_W-1:0] din_s1_q, din_s2_q;
    logic [6:0] ctl_s1_q, ctl_s2_q;
    logic oe_s1_q, oe_s2_q;

    always_ff @(posedge clk) begin
        addr_s1_q <= address;
        addr_s2_q <= addr_s1_q;
        din_s1_q <= data_in;
        din_s2_q <= din_s1_q;
        ctl_s1_q <= {address_strobe_n, count_advance_n, counter_clear_n,
                     select_low_active, select_high_active, read_write,
                     output_mode_select};
        ctl_s2_q <= ctl_s1_q;
        oe_s1_q <= output_enable_n;
        oe_s2_q <= oe_s1_q;
    end

    logic stb_n, cnt_n, clr_n, sel_lo, sel_hi, rw, pipe;
    assign {stb_n, cnt_n, clr_n, sel_lo, sel_hi, rw, pipe} = ctl_s2_q;

    // ************************************************************
    // Burst counter and access address
    // ************************************************************
    logic [ADDR_W-1:0] count_q, count_d;
    logic [ADDR_W-1:0] access_addr;

    always_comb begin
        // Chip selects are not consulted here on purpose.
        if (!clr_n) begin
            count_d = CLEAR_ADDR;
        end else if (!stb_n) begin
            count_d = addr_s2_q;
        end else if (!cnt_n) begin
            count_d = count_q + COUNT_STEP;
        end else begin
            count_d = count_q;
        end
    end

    // Clear takes effect in the same cycle as the access.
    always_comb begin
        if (!clr_n) begin
            access_addr = CLEAR_ADDR;
        end else if (!stb_n) begin
            access_addr = addr_s2_q;
        end else if (!cnt_n) begin
            access_addr = count_q + COUNT_STEP;
        end else begin
            access_addr = count_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_q <= CLEAR_ADDR;
        end else begin
            count_q <= count_d;
        end
    end

    // ************************************************************
    // Array access
    // ************************************************************
    logic selected;
    assign selected = !sel_lo && sel_hi;

    ram_access_if #(.AW(ADDR_W), .DW(DATA_W)) acc ();
    assign acc.wr_en = selected && !rw;
    assign acc.rd_en = selected && rw;
    assign acc.addr = access_addr;
    assign acc.wdata = din_s2_q;

    ram_array u_array (
        .clk(clk),
        .acc(acc)
    );

    // ************************************************************
    // Output staging
    // ************************************************************
    // Stage one holds the flow-through result; stage two adds the pipeline
    // register. The drive state follows the access one cycle back, or two cycles back when piped.
    logic rd_q, rd_d, rd2_q, rd2_d;
    logic [DATA_W-1:0] dout_q, dout_d, pipe_q, pipe_d;
    logic oe_n_q, oe_n_d;
    logic [ADDR_W-1:0] baddr_q, baddr_d;

    always_comb begin
        rd_d = acc.rd_en;
        rd2_d = rd_q;
        pipe_d = acc.rdata;
        if (pipe) begin
            dout_d = pipe_q;
            oe_n_d = !(rd2_q && !oe_s2_q);
        end else begin
            dout_d = acc.rdata;
            oe_n_d = !(rd_q && !oe_s2_q);
        end
        baddr_d = count_q;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_q <= 1'b0;
            rd2_q <= 1'b0;
            pipe_q <= DATA_ZERO;
            dout_q <= DATA_ZERO;
            oe_n_q <= 1'b1;
            baddr_q <= CLEAR_ADDR;
        end else begin
            rd_q <= rd_d;
            rd2_q <= rd2_d;
            pipe_q <= pipe_d;
            dout_q <= dout_d;
            oe_n_q <= oe_n_d;
            baddr_q <= baddr_d;
        end
    end

    assign data_out = dout_q;
    assign data_out_en_n = oe_n_q;
    assign burst_address = baddr_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_clear_zero;
        @(posedge clk) disable iff (sys_rst) !clr_n |=> count_q == CLEAR_ADDR;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("clear missed");

    property p_load;
        @(posedge clk) disable iff (sys_rst) clr_n && !stb_n |=> count_q == $past(addr_s2_q);
    endproperty
    a_load: assert property (p_load) else $error("load missed");

    property p_advance;
        @(posedge clk) disable iff (sys_rst)
            clr_n && stb_n && !cnt_n |=> count_q == $past(count_q) + COUNT_STEP;
    endproperty
    a_advance: assert property (p_advance) else $error("advance missed");

    property p_hold;
        @(posedge clk) disable iff (sys_rst)
            clr_n && stb_n && cnt_n |=> $stable(count_q);
    endproperty
    a_hold: assert property (p_hold) else $error("hold broken");

    property p_addr_sel;
        @(posedge clk) disable iff (sys_rst) clr_n && !stb_n |-> access_addr == addr_s2_q;
    endproperty
    a_addr_sel: assert property (p_addr_sel) else $error("address select");

    property p_wrap;
        @(posedge clk) disable iff (sys_rst)
            clr_n && stb_n && !cnt_n && (&count_q) |=> count_q == CLEAR_ADDR;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");

    property p_write;
        @(posedge clk) disable iff (sys_rst)
            selected && !rw |=> u_array.mem_q[$past(access_addr)] == $past(din_s2_q);
    endproperty
    a_write: assert property (p_write) else $error("write gate");

    property p_deselect_flow;
        @(posedge clk) disable iff (sys_rst) !pipe && !selected ##1 !pipe |=> data_out_en_n;
    endproperty
    a_deselect_flow: assert property (p_deselect_flow) else $error("flow float");

    property p_deselect_pipe;
        @(posedge clk) disable iff (sys_rst)
            pipe && !selected ##1 pipe ##1 pipe |=> data_out_en_n;
    endproperty
    a_deselect_pipe: assert property (p_deselect_pipe) else $error("pipe float");
endmodule

// [verif/ram_host.sv]
// Behavioural host that drives the control, address and data pins of one port.
// Assumes the bench calls drive at most once per clock cycle.
`timescale 1ns/100ps
module ram_host
    import ram_port_pkg::*;
(
    input wire logic clk,
    output logic [ADDR_W-1:0] address,
    output logic [DATA_W-1:0] data_in,
    output logic address_strobe_n,
    output logic count_advance_n,
    output logic counter_clear_n,
    output logic select_low_active,
    output logic select_high_active,
    output logic read_write,
    output logic output_mode_select,
    output logic output_enable_n
);
    initial begin
        {address_strobe_n, count_advance_n, counter_clear_n, read_write} = 4'hF;
        {select_high_active, select_low_active} = 2'h1;
        output_mode_select = 1'b0;
        output_enable_n = 1'b0;
        address = CLEAR_ADDR;
        data_in = DATA_ZERO;
    end

    // One access per 40 ns clock is slower than either mode's minimum cycle.
    // A read a whole clock after a write is already past the write-to-read
    // delay and past the window plus access time, so no extra wait is needed.
    task automatic drive(input logic [3:0] ctl, input logic [1:0] sel, input logic mode,
        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        #1;
        {address_strobe_n, count_advance_n, counter_clear_n, read_write} = ctl;
        {select_high_active, select_low_active} = sel;
        output_mode_select = mode;
        address = a;
        data_in = d;
    endtask
endmodule

// [verif/test_ram_port.sv]
// Self-checking bench for one RAM port driven by the behavioural host.
// Assumes data three edges after the port samples a read, four when piped.
`timescale 1ns/100ps
module test_ram_port
    import ram_port_pkg::*;
;
    localparam logic [3:0] LD_RD = 4'h7, LD_WR = 4'h6, ADV_RD = 4'hB, ADV_WR = 4'hA;
    localparam logic [3:0] HOLD_RD = 4'hF, CLR_LD = 4'h5;
    localparam logic [1:0] ON = 2'h2, OFF0 = 2'h1, OFF1 = 2'h0;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] address, burst_address, cnt;
    logic [DATA_W-1:0] data_in, data_out;
    logic address_strobe_n, count_advance_n, counter_clear_n, select_low_active;
    logic select_high_active, read_write, output_mode_select, output_enable_n;
    logic data_out_en_n;
    logic mode = 1'b0;
    int cyc = 0;
    int error_cnt = 0;
    int samples_checked = 0;
    logic exp_en [int];
    logic [DATA_W-1:0] exp_dat [int];
    logic [ADDR_W-1:0] exp_ba [int];
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    logic [ADDR_W-1:0] addr_tab [4] = '{17'h00000, 17'h1FFFF, 17'h0A5A5, 17'h15A5A};
    logic [DATA_W-1:0] data_tab [4] = '{8'h3C, 8'hC3, 8'h5A, 8'hA5};

    ram_host host(.clk(clk), .address(address), .data_in(data_in),
        .address_strobe_n(address_strobe_n), .count_advance_n(count_advance_n),
        .counter_clear_n(counter_clear_n), .select_low_active(select_low_active),
        .select_high_active(select_high_active), .read_write(read_write),
        .output_mode_select(output_mode_select), .output_enable_n(output_enable_n));

    ram_port dut(.clk(clk), .sys_rst(sys_rst), .address(address), .data_in(data_in),
        .address_strobe_n(address_strobe_n), .count_advance_n(count_advance_n),
        .counter_clear_n(counter_clear_n), .select_low_active(select_low_active),
        .select_high_active(select_high_active), .read_write(read_write),
        .output_mode_select(output_mode_select), .output_enable_n(output_enable_n),
        .data_out(data_out), .data_out_en_n(data_out_en_n), .burst_address(burst_address));

    always #20 clk = ~clk;

    task automatic results();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // ****************************************************************
    // Access model: counter and array are tracked here, outputs queued.
    // ****************************************************************
    task automatic op(input logic [3:0] ctl, input logic [1:0] sel,
        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic on;
        int due;
        on = (sel === ON);
        if (!ctl[1]) begin
            cnt = CLEAR_ADDR;
        end else if (!ctl[3]) begin
            cnt = a;
        end else if (!ctl[2]) begin
            cnt = cnt + COUNT_STEP;
        end
        host.drive(ctl, sel, mode, a, d);
        due = cyc + (mode ? 5 : 4);
        exp_ba[cyc + 4] = cnt;
        exp_en[due] = !(on && ctl[0]);
        if (on && ctl[0]) begin
            exp_dat[due] = mem[cnt];
        end
        if (on && !ctl[0]) begin
            mem[cnt] = d;
        end
    endtask

    task automatic read_set();
        for (int i = 0; i < 4; i++) begin
            op(LD_RD, ON, addr_tab[i ^ 3], 8'hFF);
        end
        op(LD_RD, OFF0, addr_tab[0], 8'h00);
        op(LD_RD, OFF1, addr_tab[1], 8'h00);
        op(LD_RD, ON, addr_tab[1], 8'h00);
    endtask

    // Each edge's output is judged against the controls of its access cycle.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        #2;
        if (exp_en.exists(cyc)) begin
            chk(ADDR_W'(data_out_en_n), ADDR_W'(exp_en[cyc]));
            if (exp_dat.exists(cyc)) begin
                chk(ADDR_W'(data_out), ADDR_W'(exp_dat[cyc]));
            end
        end
        if (exp_ba.exists(cyc)) begin
            chk(burst_address, exp_ba[cyc]);
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        #1 sys_rst = 1'b0;
        chk(ADDR_W'(data_out), ADDR_W'(DATA_ZERO));
        chk(ADDR_W'(data_out_en_n), ADDR_W'(1'b1));
        chk(burst_address, CLEAR_ADDR);
        for (int i = 0; i < 4; i++) begin
            op(LD_WR, ON, addr_tab[i], data_tab[i]);
        end
        read_set();
        op(LD_WR, OFF0, addr_tab[2], 8'hFF);
        op(LD_WR, ON, addr_tab[2], data_tab[2]);
        op(LD_WR, ON, 17'h1FFFE, 8'h11);
        op(ADV_WR, ON, 17'h0F0F0, 8'h22);
        op(ADV_WR, ON, 17'h0F0F0, 8'h33);
        op(HOLD_RD, ON, 17'h0F0F0, 8'h00);
        op(LD_RD, OFF0, 17'h1FFFE, 8'h00);
        op(HOLD_RD, ON, 17'h0F0F0, 8'h00);
        op(ADV_RD, OFF1, 17'h0F0F0, 8'h00);
        op(HOLD_RD, ON, 17'h0F0F0, 8'h00);
        op(CLR_LD, ON, 17'h1FFFF, 8'h00);
        // The output mux follows the current mode, so one idle flow cycle lets
        // the last flow read leave before the mode turns.
        host.drive(HOLD_RD, OFF0, mode, 17'h00000, 8'h00);
        mode = 1'b1;
        host.drive(HOLD_RD, OFF0, mode, 17'h00000, 8'h00);
        repeat (8) @(posedge clk);
        read_set();
        op(HOLD_RD, OFF0, 17'h00000, 8'h00);
        repeat (8) @(posedge clk);
        results();
    end

    initial begin
        #20000;
        error_cnt++;
        results();
    end
endmodule
